// ===== core/event_router_pkg.sv
package event_router_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_CHANNELS = 8;
  localparam int NUM_USERS    = 24;
  localparam int NUM_PINS     = 6;
  localparam int SYNC_STAGES  = 3;

  // ==========================================================
  // Register map (byte offsets, 8-bit data)
  localparam logic [7:0] STROBE_OFFSET = 8'h00;
  localparam logic [7:0] STATE_OFFSET  = 8'h08;
  localparam logic [7:0] CHANNEL_BASE  = 8'h10;
  localparam logic [7:0] USER_BASE     = 8'h20;
  localparam logic [7:0] CHANNEL_COUNT = 8'h08;
  localparam logic [7:0] USER_COUNT    = 8'h18;
  localparam logic [7:0] CHANNEL_RESET = 8'h00;
  localparam logic [7:0] USER_RESET    = 8'h00;
  localparam logic [7:0] READ_ZERO     = 8'h00;

  // User selection: 0 = none, n+1 = channel n
  localparam logic [7:0] USER_OFF      = 8'h00;
  localparam logic [7:0] USER_CH_FIRST = 8'h01;

  // ==========================================================
  // Generator codes and their match masks
  localparam logic [7:0] GEN_OFF        = 8'h00;
  localparam logic [7:0] GEN_DEBUG      = 8'h01;
  localparam logic [7:0] GEN_RTC_OVF    = 8'h06;
  localparam logic [7:0] GEN_RTC_CMP    = 8'h07;
  localparam logic [7:0] GEN_PIT_BASE   = 8'h08;
  localparam logic [7:0] GEN_LUT_BASE   = 8'h10;
  localparam logic [7:0] GEN_CMP        = 8'h20;
  localparam logic [7:0] GEN_ADC        = 8'h24;
  localparam logic [7:0] GEN_PORT0_BASE = 8'h40;
  localparam logic [7:0] GEN_PORT1_BASE = 8'h48;
  localparam logic [7:0] GEN_BAUD_BASE  = 8'h60;
  localparam logic [7:0] GEN_SPI        = 8'h68;
  localparam logic [7:0] GEN_TA_OVF     = 8'h80;
  localparam logic [7:0] GEN_TA_HUNF    = 8'h81;
  localparam logic [7:0] GEN_TA_CMP0    = 8'h84;
  localparam logic [7:0] GEN_TA_CMP1    = 8'h85;
  localparam logic [7:0] GEN_TA_CMP2    = 8'h86;
  localparam logic [7:0] GEN_TB_BASE    = 8'ha0;
  localparam logic [7:0] MASK_EXACT     = 8'hff;
  localparam logic [7:0] MASK_FOUR      = 8'hfc;
  localparam logic [7:0] MASK_EIGHT     = 8'hf8;
  localparam logic [7:0] MASK_TB        = 8'hf1;

  // Periodic tap index tops for even and odd channels
  localparam logic [2:0] PIT_TOP_EVEN = 3'h7;
  localparam logic [2:0] PIT_TOP_ODD  = 3'h3;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       write;
    logic       read;
  } bus_req_t;

  // pit_taps bit i = counter divided by 2^(i+6)
  typedef struct packed {
    logic                 debug_sync;
    logic                 rtc_ovf;
    logic                 rtc_cmp;
    logic [7:0]           pit_taps;
    logic [3:0]           logic_table;
    logic                 comparator;
    logic                 adc_ready;
    logic [5:0][7:0]      port_pins;
    logic [7:0]           serial_baud;
    logic                 spi_clock;
    logic                 timer_a_ovf;
    logic                 timer_a_hunf;
    logic [2:0]           timer_a_cmp;
    logic [7:0]           timer_b_capture_flag;
  } gen_events_t;

endpackage

// ===== core/event_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Multi-stage level synchroniser, one lane per channel
module event_sync #(
  parameter int WIDTH  = 8,
  parameter int STAGES = 3
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rstn,
  // Lanes
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [STAGES-1:0][WIDTH-1:0] stage_reg;

  // Shift chain; each flop is read only by the next stage, the last by sync_out
  always_ff @(posedge clock) begin
    if (!rstn) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= {stage_reg[STAGES-2:0], async_in};
    end
  end

  assign sync_out = stage_reg[STAGES-1];

endmodule // event_sync

`default_nettype wire

// ===== core/peripheral_event_router.sv
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module peripheral_event_router (
  // Clock and reset
  input  wire logic                              clock,
  input  wire logic                              rstn,
  // Register port
  input  wire event_router_pkg::bus_req_t        bus_req,
  output logic [7:0]                             rdata,
  // Generator events
  input  wire event_router_pkg::gen_events_t     gens,
  // Channel subchannels
  output logic [event_router_pkg::NUM_CHANNELS-1:0] channel_async,
  output logic [event_router_pkg::NUM_CHANNELS-1:0] channel_sync,
  // User events
  output logic [event_router_pkg::NUM_USERS-1:0]    user_async,
  output logic [event_router_pkg::NUM_USERS-1:0]    user_sync,
  // Event pins
  output logic [event_router_pkg::NUM_PINS-1:0]     event_pin_output
);

  import event_router_pkg::*;

  // ==========================================================
  // Fixed user numbers

  // Users 9 to 14 drive the six event pins, ports A to F in order
  localparam int PIN_USER_FIRST = 9;
  localparam int PIN_USER_LAST  = PIN_USER_FIRST + NUM_PINS - 1;

  // User number map
  // User 0-7: logic table inputs, asynchronous level
  // User 8: converter start, asynchronous edge
  // User 9-14: event pins, raw level, no detection
  // User 15-23: further users, each of its own class
  // Selection 0 is none, 1-8 channel 0-7, anything else none
  // Selection is per user; sharing a channel costs nothing

  // ==========================================================
  // Helper functions

  // Code compare under a mask of significant bits
  function automatic logic code_match(
    input logic [7:0] code,
    input logic [7:0] base,
    input logic [7:0] mask
  );
    code_match = ((code & mask) == base);
  endfunction

  // Generators that are already clock-aligned
  // These bypass the synchroniser and keep their exact timing
  function automatic logic gen_is_sync(input logic [7:0] code);
    gen_is_sync = code_match(code, GEN_DEBUG, MASK_EXACT)
               || code_match(code, GEN_ADC, MASK_EXACT)
               || code_match(code, GEN_BAUD_BASE, MASK_EIGHT)
               || code_match(code, GEN_SPI, MASK_EXACT)
               || code_match(code, GEN_TA_OVF, MASK_EXACT)
               || code_match(code, GEN_TA_HUNF, MASK_EXACT)
               || code_match(code, GEN_TA_CMP0, MASK_EXACT)
               || code_match(code, GEN_TA_CMP1, MASK_EXACT)
               || code_match(code, GEN_TA_CMP2, MASK_EXACT)
               || code_match(code, GEN_TB_BASE, MASK_TB);
  endfunction

  // Generator code map
  // Code 0x00: channel off
  // Code 0x01: debug port sync character, clocked
  // Code 0x06, 0x07: counter overflow and compare, asynchronous
  // Code 0x08-0x0b: periodic taps; even channels slow set, odd fast set
  // Code 0x10-0x13: logic table outputs, asynchronous
  // Code 0x20: comparator result, asynchronous level
  // Code 0x24: converter result ready, clocked
  // Code 0x40-0x4f: port pins, two ports per channel pair, none on 6, 7
  // Code 0x60-0x67: serial baud clocks, clocked
  // Code 0x68: serial host clock, clocked
  // Code 0x80-0x86: first timer overflow, underflow, compares, clocked
  // Code 0xa0-0xae: second timer capture flags, even codes, clocked
  // Generator multiplexer for one channel; unknown codes give zero
  function automatic logic route_event(
    input logic [7:0]  code,
    input logic [2:0]  ch,
    input gen_events_t g
  );
    logic [2:0] tap_top;
    logic [2:0] tap_idx;
    logic [1:0] pair;
    logic       pair_ok;
    logic [2:0] port0_sel;
    logic [2:0] port1_sel;
    tap_top   = ch[0] ? PIT_TOP_ODD : PIT_TOP_EVEN;
    tap_idx   = tap_top - {1'b0, code[1:0]};
    pair      = ch[2:1];
    pair_ok   = (pair != 2'h3);
    port0_sel = {pair, 1'b0};
    port1_sel = {pair, 1'b1};
    route_event = 1'b0;
    if (code_match(code, GEN_OFF, MASK_EXACT)) begin
      route_event = 1'b0;
    end else if (code_match(code, GEN_DEBUG, MASK_EXACT)) begin
      route_event = g.debug_sync;
    end else if (code_match(code, GEN_RTC_OVF, MASK_EXACT)) begin
      route_event = g.rtc_ovf;
    end else if (code_match(code, GEN_RTC_CMP, MASK_EXACT)) begin
      route_event = g.rtc_cmp;
    end else if (code_match(code, GEN_PIT_BASE, MASK_FOUR)) begin
      route_event = g.pit_taps[tap_idx];
    end else if (code_match(code, GEN_LUT_BASE, MASK_FOUR)) begin
      route_event = g.logic_table[code[1:0]];
    end else if (code_match(code, GEN_CMP, MASK_EXACT)) begin
      route_event = g.comparator;
    end else if (code_match(code, GEN_ADC, MASK_EXACT)) begin
      route_event = g.adc_ready;
    end else if (code_match(code, GEN_PORT0_BASE, MASK_EIGHT)) begin
      route_event = pair_ok && g.port_pins[port0_sel][code[2:0]];
    end else if (code_match(code, GEN_PORT1_BASE, MASK_EIGHT)) begin
      route_event = pair_ok && g.port_pins[port1_sel][code[2:0]];
    end else if (code_match(code, GEN_BAUD_BASE, MASK_EIGHT)) begin
      route_event = g.serial_baud[code[2:0]];
    end else if (code_match(code, GEN_SPI, MASK_EXACT)) begin
      route_event = g.spi_clock;
    end else if (code_match(code, GEN_TA_OVF, MASK_EXACT)) begin
      route_event = g.timer_a_ovf;
    end else if (code_match(code, GEN_TA_HUNF, MASK_EXACT)) begin
      route_event = g.timer_a_hunf;
    end else if (code_match(code, GEN_TA_CMP0, MASK_EXACT)) begin
      route_event = g.timer_a_cmp[0];
    end else if (code_match(code, GEN_TA_CMP1, MASK_EXACT)) begin
      route_event = g.timer_a_cmp[1];
    end else if (code_match(code, GEN_TA_CMP2, MASK_EXACT)) begin
      route_event = g.timer_a_cmp[2];
    end else if (code_match(code, GEN_TB_BASE, MASK_TB)) begin
      route_event = g.timer_b_capture_flag[code[3:1]];
    end
  endfunction

  // User channel pick: 0 is no channel, n+1 is channel n
  function automatic logic pick_channel(
    input logic [7:0]              sel,
    input logic [NUM_CHANNELS-1:0] lanes
  );
    logic [7:0] idx;
    idx = sel - USER_CH_FIRST;
    pick_channel = 1'b0;
    if (sel != USER_OFF && idx < CHANNEL_COUNT) begin
      pick_channel = lanes[idx[2:0]];
    end
  endfunction

  // ==========================================================
  // Registers and decode

  // Configuration, strobe and read state
  logic [NUM_CHANNELS-1:0][7:0] channel_reg;
  logic [NUM_USERS-1:0][7:0]    user_reg;
  logic [NUM_CHANNELS-1:0]      strobe_reg;
  logic [NUM_CHANNELS-1:0]      strobe_next;
  logic [7:0]                   rdata_reg;
  logic [7:0]                   rdata_next;
  logic [7:0]                   ch_off;
  logic [7:0]                   user_off;
  logic                         ch_hit;
  logic                         user_hit;
  logic                         strobe_hit;
  logic                         state_hit;

  // Register map
  // Offset 0x00: strobe, write only, reads zero
  // Offset 0x08: synchronous lane state, read only
  // Offset 0x10-0x17: generator select per channel
  // Offset 0x20-0x37: channel select per user
  // Holes ignore writes and read zero

  // Window decode of the register address
  assign strobe_hit = (bus_req.addr == STROBE_OFFSET);
  assign state_hit  = (bus_req.addr == STATE_OFFSET);
  assign ch_off   = bus_req.addr - CHANNEL_BASE;
  assign user_off = bus_req.addr - USER_BASE;
  assign ch_hit   = (bus_req.addr >= CHANNEL_BASE) && (ch_off < CHANNEL_COUNT);
  assign user_hit = (bus_req.addr >= USER_BASE) && (user_off < USER_COUNT);

  // Generator selection per channel, all off after reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      channel_reg <= {NUM_CHANNELS{CHANNEL_RESET}};
    end else if (bus_req.write && ch_hit) begin
      channel_reg[ch_off[2:0]] <= bus_req.wdata;
    end
  end

  // Channel selection per user, indexed by user number
  always_ff @(posedge clock) begin
    if (!rstn) begin
      user_reg <= {NUM_USERS{USER_RESET}};
    end else if (bus_req.write && user_hit) begin
      user_reg[user_off[4:0]] <= bus_req.wdata;
    end
  end

  // Strobe is write-only; each written one lasts a single clock
  // Zero bits give zero, so untouched channels see nothing
  always_comb begin
    strobe_next = '0;
    if (bus_req.write && strobe_hit) begin
      strobe_next = bus_req.wdata;
    end
  end

  // One clock of inversion, then back to zero by itself
  always_ff @(posedge clock) begin
    if (!rstn) begin
      strobe_reg <= '0;
    end else begin
      strobe_reg <= strobe_next;
    end
  end

  // ==========================================================
  // Channel datapath

  // Per-channel raw level, its clock class and resynchronised copy
  logic [NUM_CHANNELS-1:0] raw_event;
  logic [NUM_CHANNELS-1:0] raw_is_sync;
  logic [NUM_CHANNELS-1:0] raw_resynced;

  // Combinational generator mux; no flop so async users see it live
  // Unknown codes and the off code both route a constant zero
  always_comb begin
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      raw_event[c]   = route_event(channel_reg[c], 3'(c), gens);
      raw_is_sync[c] = gen_is_sync(channel_reg[c]);
    end
  end

  // Resynchroniser for asynchronous sources; 2-3 clocks of latency
  // Three flops: an edge between clocks lands after two to three
  // Every lane runs even for clocked sources; the bypass picks later
  event_sync #(
    .WIDTH  (NUM_CHANNELS),
    .STAGES (SYNC_STAGES)
  ) event_sync_inst (
    .clock    (clock),
    .rstn     (rstn),
    .async_in (raw_event),
    .sync_out (raw_resynced)
  );

  // Strobe is applied after the synchroniser, so it is never delayed
  // and both subchannels carry the very same one-cycle inversion.
  always_comb begin
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      channel_async[c] = raw_event[c] ^ strobe_reg[c];
      channel_sync[c]  = (raw_is_sync[c] ? raw_event[c] : raw_resynced[c])
                       ^ strobe_reg[c];
    end
  end

  // ==========================================================
  // Sleep, halt and clock notes

  // No sleep or halt input: routing never pauses
  // Mux and fan-out combinational: async users act between edges
  // Async generators reach async users with no clock at all
  // Clocked generators and users need their own clock running
  // Sync lanes of clocked sources change only on edges anyway
  // Clock stopped: no strobes, sync lanes hold their last value
  // Limitation: a strobe during a clocked pulse cancels that pulse

  // ==========================================================
  // User fan-out

  // Every user reads its own selection; sharing a channel is free
  // Async lane: no flop, for pins, tables and single-shot capture
  // Sync lane: clock-aligned only, for edge or level detecting users
  always_comb begin
    for (int u = 0; u < NUM_USERS; u++) begin
      user_async[u] = pick_channel(user_reg[u], channel_async);
      user_sync[u]  = pick_channel(user_reg[u], channel_sync);
    end
  end

  // Pin outputs forward the raw asynchronous level unregistered
  // No flop here: a pin mirrors the channel even with the clock off
  assign event_pin_output = user_async[PIN_USER_LAST:PIN_USER_FIRST];

  // ==========================================================
  // Read port

  // Read data valid in the cycle after the read strobe only
  // Zero otherwise, so a stale value is never mistaken for data
  always_comb begin
    rdata_next = READ_ZERO;
    if (bus_req.read) begin
      if (state_hit) begin
        rdata_next = channel_sync;
      end else if (ch_hit) begin
        rdata_next = channel_reg[ch_off[2:0]];
      end else if (user_hit) begin
        rdata_next = user_reg[user_off[4:0]];
      end
    end
  end

  // Registered read data
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata_reg <= READ_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

endmodule // peripheral_event_router

`default_nettype wire

// ===== test/router_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Port-level checks for the event router
module router_checker (
  // Clock and reset
  input wire logic                                     clock,
  input wire logic                                     rstn,
  // Register port
  input wire event_router_pkg::bus_req_t               bus_req,
  input wire logic [7:0]                               rdata,
  // Generators and channels
  input wire event_router_pkg::gen_events_t            gens,
  input wire logic [event_router_pkg::NUM_CHANNELS-1:0] channel_async,
  input wire logic [event_router_pkg::NUM_CHANNELS-1:0] channel_sync,
  // Users and pins
  input wire logic [event_router_pkg::NUM_USERS-1:0]    user_async,
  input wire logic [event_router_pkg::NUM_USERS-1:0]    user_sync,
  input wire logic [event_router_pkg::NUM_PINS-1:0]     event_pin_output
);
  import event_router_pkg::*;
  logic       strobe_wr;
  logic       u0_on;
  logic       port_mode;
  logic [7:0] ch0_reg;
  logic [7:0] sel0_reg;
  logic [7:0] sel0_idx;

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  // Shadow of channel 0 and user 0 settings, so checks need no peeking inside
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ch0_reg  <= CHANNEL_RESET;
      sel0_reg <= USER_RESET;
    end else if (bus_req.write) begin
      if (bus_req.addr == CHANNEL_BASE) ch0_reg <= bus_req.wdata;
      if (bus_req.addr == USER_BASE) sel0_reg <= bus_req.wdata;
    end
  end

  // Decoded conditions; strobes excluded where an inversion would blur a check
  assign strobe_wr = bus_req.write && (bus_req.addr == STROBE_OFFSET);
  assign sel0_idx  = sel0_reg - USER_CH_FIRST;
  assign u0_on     = (sel0_reg != USER_OFF) && (sel0_reg <= CHANNEL_COUNT);
  assign port_mode = (ch0_reg == GEN_PORT0_BASE) && !strobe_wr;

  pin_mirror_a: assert property (event_pin_output == user_async[14:9])
    else $error("event pins differ from their user lanes");
  strobe_flip_a: assert property (strobe_wr && !$past(strobe_wr) ##1 $stable(gens)
    |-> (channel_async ^ $past(channel_async)) == $past(bus_req.wdata))
    else $error("strobe did not invert exactly the written channels");
  strobe_once_a: assert property (strobe_wr && !$past(strobe_wr)
    ##1 (!bus_req.write && $stable(gens)) ##1 $stable(gens)
    |-> channel_async == $past(channel_async, 2))
    else $error("strobe inversion lasted more than one cycle");
  state_read_a: assert property (bus_req.read && bus_req.addr == STATE_OFFSET
    |=> rdata == $past(channel_sync))
    else $error("state read does not match sync lanes");
  user_route_a: assert property (user_async[0] == (u0_on && channel_async[sel0_idx[2:0]])
    && user_sync[0] == (u0_on && channel_sync[sel0_idx[2:0]]))
    else $error("user 0 does not follow its selected channel");
  sync_direct_a: assert property (ch0_reg == GEN_TA_OVF && !$past(strobe_wr)
    |-> channel_async[0] == gens.timer_a_ovf && channel_sync[0] == gens.timer_a_ovf)
    else $error("clocked generator not passed straight through");
  channel_off_a: assert property (ch0_reg == GEN_OFF && !$past(strobe_wr)
    |-> !channel_async[0])
    else $error("channel switched off still carries an event");
  async_resync_a: assert property (port_mode && $changed(gens.port_pins[0][0])
    ##1 (port_mode && $stable(gens.port_pins[0][0]))[*3] |-> channel_sync[0] == gens.port_pins[0][0])
    else $error("pin level not resynchronised within three cycles");

  // Main scenarios reached
  cover property (strobe_wr && bus_req.wdata != 8'h00);
  cover property (u0_on && user_async[0]);
  cover property (port_mode && channel_sync[0]);
endmodule // router_checker

bind peripheral_event_router router_checker router_checker_inst (.clock(clock), .rstn(rstn),
  .bus_req(bus_req), .rdata(rdata), .gens(gens), .channel_async(channel_async),
  .channel_sync(channel_sync), .user_async(user_async), .user_sync(user_sync),
  .event_pin_output(event_pin_output));

`default_nettype wire

// ===== test/event_generators.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Generator peripherals feeding the router
module event_generators (
  // Clock and reset
  input wire logic                           clock,
  input wire logic                           rstn,
  // Requests from the bench
  input wire logic                           ovf_req,
  input wire logic                           capture_flag_req,
  input wire logic                           pin_req,
  // Generator lines
  output var event_router_pkg::gen_events_t gens
);
  import event_router_pkg::*;

  // Pulses never exceed one cycle; async levels hold for many clocks
  always_ff @(posedge clock) begin
    if (!rstn) begin
      gens <= '0;
    end else begin
      gens.timer_a_ovf     <= ovf_req && !gens.timer_a_ovf;
      gens.timer_b_capture_flag[0] <= capture_flag_req && !gens.timer_b_capture_flag[0];
      gens.port_pins[0][0] <= pin_req;
      gens.debug_sync      <= ovf_req && !gens.debug_sync;
      gens.pit_taps[3]     <= pin_req;
      gens.logic_table[1]  <= pin_req;
      gens.comparator      <= pin_req;
      gens.port_pins[3][2] <= pin_req;
    end
  end
endmodule // event_generators

`default_nettype wire

// ===== test/test_peripheral_event_router.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Bench for the event router
module test_peripheral_event_router;
  import event_router_pkg::*;
  logic                    clock;
  logic                    rstn;
  bus_req_t                bus_req;
  logic [7:0]              rdata;
  logic [7:0]              rd_val;
  gen_events_t             gens;
  logic [NUM_CHANNELS-1:0] channel_async;
  logic [NUM_CHANNELS-1:0] channel_sync;
  logic [NUM_USERS-1:0]    user_async;
  logic [NUM_USERS-1:0]    user_sync;
  logic [NUM_PINS-1:0]     event_pin_output;
  logic                    ovf_req;
  logic                    capture_flag_req;
  logic                    pin_req;
  int                      n_mismatch;
  int                      n_compared;

  peripheral_event_router peripheral_event_router_inst (.clock(clock), .rstn(rstn),
    .bus_req(bus_req), .rdata(rdata), .gens(gens), .channel_async(channel_async),
    .channel_sync(channel_sync), .user_async(user_async), .user_sync(user_sync),
    .event_pin_output(event_pin_output));
  event_generators event_generators_inst (.clock(clock), .rstn(rstn), .ovf_req(ovf_req),
    .capture_flag_req(capture_flag_req), .pin_req(pin_req), .gens(gens));

  // 100 MHz clock
  always #5 clock = ~clock;

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One-cycle bus strobes; the gap edge keeps a strobe from being driven twice
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clock);
    bus_req.write <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge clock);
    bus_req.read <= 1'b0;
    #1;
    rd_val = rdata;
  endtask

  // Reset values and an unmapped hole
  task automatic reg_defaults;
    rd(CHANNEL_BASE);
    check(rd_val, CHANNEL_RESET);
    rd(USER_BASE + 8'h17);
    check(rd_val, USER_RESET);
    rd(8'h18);
    check(rd_val, READ_ZERO);
    check(channel_async, 8'h00);
  endtask

  // Clocked pulses reach both lanes and several users at once
  task automatic sync_route;
    wr(CHANNEL_BASE, GEN_TA_OVF);
    wr(CHANNEL_BASE + 8'h01, GEN_TB_BASE);
    wr(CHANNEL_BASE + 8'h03, GEN_DEBUG);
    wr(USER_BASE, USER_CH_FIRST);
    wr(USER_BASE + 8'h01, USER_CH_FIRST);
    wr(USER_BASE + 8'h02, USER_CH_FIRST + 8'h01);
    rd(CHANNEL_BASE + 8'h01);
    check(rd_val, GEN_TB_BASE);
    @(posedge clock);
    ovf_req  <= 1'b1;
    capture_flag_req <= 1'b1;
    @(posedge clock);
    ovf_req  <= 1'b0;
    capture_flag_req <= 1'b0;
    #1;
    check(channel_sync[1:0], 2'b11);
    check(channel_async[1:0], 2'b11);
    check(channel_sync[3], 1'b1);
    check(user_sync[2:0], 3'b111);
    @(posedge clock);
    #1;
    check(channel_sync[1:0], 2'b00);
  endtask

  // Software strobes on two channels, one of them switched off
  task automatic soft_events;
    wr(STROBE_OFFSET, 8'h05);
    check(channel_async, 8'h05);
    check(channel_sync, 8'h05);
    check(user_async[2:0], 3'b011);
    @(posedge clock);
    #1;
    check(channel_async, 8'h00);
    rd(STATE_OFFSET);
    check(rd_val, 8'h00);
  endtask

  // Pin event: raw lane at once, sync lane only after the synchroniser
  task automatic async_route;
    int k;
    k = 0;
    wr(CHANNEL_BASE, GEN_PORT0_BASE);
    wr(USER_BASE + 8'h09, USER_CH_FIRST);
    wr(CHANNEL_BASE + 8'h01, GEN_PIT_BASE);
    wr(CHANNEL_BASE + 8'h02, GEN_LUT_BASE + 8'h01);
    wr(CHANNEL_BASE + 8'h03, GEN_PORT1_BASE + 8'h02);
    wr(CHANNEL_BASE + 8'h04, GEN_CMP);
    @(posedge clock);
    pin_req <= 1'b1;
    @(posedge clock);
    #1;
    check(channel_async[0], 1'b1);
    check(event_pin_output[0], 1'b1);
    check(channel_sync[0], 1'b0);
    check(channel_sync[4:1], 4'h0);
    check(channel_async[4:1], 4'hf);
    while (channel_sync[0] !== 1'b1 && k < 3) begin
      @(posedge clock);
      #1;
      k++;
    end
    check(channel_sync[0], 1'b1);
    check(channel_sync[4:1], 4'hf);
    check(k >= 2, 1'b1);
    if (channel_sync[0] !== 1'b1) end_sim;
    wr(CHANNEL_BASE, GEN_OFF);
    check(channel_async[0], 1'b0);
    @(posedge clock);
    pin_req <= 1'b0;
  endtask

  // Main sequence
  initial begin
    clock      = 1'b0;
    rstn       = 1'b0;
    bus_req    = '0;
    ovf_req    = 1'b0;
    capture_flag_req   = 1'b0;
    pin_req    = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    reg_defaults;
    sync_route;
    soft_events;
    async_route;
    end_sim;
  end

  // Hang guard
  initial begin
    #100000;
    n_mismatch++;
    end_sim;
  end
endmodule // test_peripheral_event_router

`default_nettype wire
